// *** tsr_pkg.sv ***
package tsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SRC_FLAGS = 8'h22;
  localparam logic [7:0] ADDR_CTRL = 8'h23;
  localparam logic [7:0] ADDR_LIM_LO = 8'h24;
  localparam logic [7:0] ADDR_LIM_HI = 8'h25;
  localparam logic [7:0] ADDR_PSYS = 8'h26;
  localparam logic [7:0] ADDR_VBUS = 8'h27;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'ha8;
  localparam logic [7:0] LIM_LO_RESET = 8'h00;
  localparam logic [7:0] LIM_HI_RESET = 8'h41;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the throttle control register
  // ----------------------------------------------------------------
  localparam int CTRL_RSVD7_BIT = 7;
  localparam int CTRL_HOLD_BIT = 6;
  localparam int CTRL_WIDTH_MSB = 5;
  localparam int CTRL_WIDTH_LSB = 4;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_RSVD2_BIT = 2;
  localparam int CTRL_FAIL_BIT = 1;
  localparam int CTRL_EXIT_BIT = 0;
  localparam logic CTRL_RSVD7_VAL = 1'b1;
  localparam logic CTRL_RSVD2_VAL = 1'b0;
  localparam logic CLEAR_IDLE_VAL = 1'b1;

  // ----------------------------------------------------------------
  // Throttle source flags: bits 7..2 sources, 1 pack, 0 adapter
  // ----------------------------------------------------------------
  localparam int SRC_NUM = 6;
  localparam int FLAG_NUM = 8;
  localparam int FLAG_PACK_BIT = 1;
  localparam int FLAG_ADAPTER_BIT = 0;

  // ----------------------------------------------------------------
  // Input current limit field
  // ----------------------------------------------------------------
  localparam int LIM_CODE_W = 7;
  localparam int LIM_MA_W = 13;
  localparam logic [12:0] LIMIT_STEP_MA = 13'h0032;
  localparam logic [12:0] LIMIT_OFFSET_MA = 13'h0032;

  // ----------------------------------------------------------------
  // Assist failure counting
  // ----------------------------------------------------------------
  localparam logic [3:0] ASSIST_FAIL_LIMIT = 4'h7;

  // ----------------------------------------------------------------
  // Alert pulse widths
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_100US = 2'h0;
  localparam logic [1:0] WIDTH_1MS = 2'h1;
  localparam logic [1:0] WIDTH_10MS = 2'h2;
  localparam logic [1:0] WIDTH_5MS = 2'h3;
  localparam int CLK_PERIOD_NS = 8;
  localparam int W100US_US = 100;
  localparam int W1MS_US = 1000;
  localparam int W10MS_US = 10000;
  localparam int W5MS_US = 5000;
  localparam int W100US_CYC = (W100US_US * 1000) / CLK_PERIOD_NS;
  localparam int W1MS_CYC = (W1MS_US * 1000) / CLK_PERIOD_NS;
  localparam int W10MS_CYC = (W10MS_US * 1000) / CLK_PERIOD_NS;
  localparam int W5MS_CYC = (W5MS_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 21;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALERT_IDLE = 3'h1,
    ALERT_PULSE = 3'h2,
    ALERT_HOLD = 3'h4
  } tsr_alert_state_t;

  typedef struct packed {
    logic hold_en;
    logic [1:0] width;
    logic clear_bit;
  } tsr_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } tsr_reg_req_t;

endpackage

// *** tsr_pulse_timer.sv ***
`timescale 1ns/1ns
module tsr_pulse_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic stop_i,
  input wire logic [20:0] count_i,
  output logic done_o
);

  logic [20:0] cnt_reg;
  logic [20:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (load_i)
    begin
      cnt_next = count_i;
    end
    else if (stop_i)
    begin
      cnt_next = 21'h000000;
    end
    else if (cnt_reg != 21'h000000)
    begin
      cnt_next = cnt_reg - 21'h000001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= 21'h000000;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // Last cycle of the loaded width
  assign done_o = (cnt_reg == 21'h000001) && !load_i;

endmodule // tsr_pulse_timer

// *** tsr_throttle_status_register_bank.sv ***
`timescale 1ns/1ns
module tsr_throttle_status_register_bank #(
  parameter int W100US_CYC = tsr_pkg::W100US_CYC,
  parameter int W1MS_CYC = tsr_pkg::W1MS_CYC,
  parameter int W10MS_CYC = tsr_pkg::W10MS_CYC,
  parameter int W5MS_CYC = tsr_pkg::W5MS_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [5:0] SRC_TRIG_I,
  input wire logic PACK_BELOW_REMOVAL_I,
  input wire logic BUS_BELOW_CONV_I,
  input wire logic IN_ASSIST_I,
  input wire logic ASSIST_FAIL_I,
  input wire logic ASSIST_OK_I,
  input wire logic OPT_DONE_I,
  input wire logic [6:0] OPT_LIMIT_I,
  input wire logic RESULT_VALID_I,
  input wire logic [7:0] PSYS_RESULT_I,
  input wire logic [7:0] VBUS_RESULT_I,
  output logic ALERT_N_O,
  output logic ASSIST_LATCH_OFF_O,
  output logic IN_ASSIST_STATUS_O,
  output logic [12:0] INPUT_LIMIT_MA_O
);

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  tsr_pkg::tsr_reg_req_t req;
  logic wr_ctrl;
  logic wr_lim_lo;
  logic wr_lim_hi;
  logic rd_flags;
  logic clear_req;

  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, data: REG_WDATA_I};
  assign wr_ctrl = req.wr && (req.addr == tsr_pkg::ADDR_CTRL);
  assign wr_lim_lo = req.wr && (req.addr == tsr_pkg::ADDR_LIM_LO);
  assign wr_lim_hi = req.wr && (req.addr == tsr_pkg::ADDR_LIM_HI);
  assign rd_flags = req.rd && (req.addr == tsr_pkg::ADDR_SRC_FLAGS);
  assign clear_req = wr_ctrl && !req.data[tsr_pkg::CTRL_CLEAR_BIT];

  // ----------------------------------------------------------------
  // Trigger sources and flags
  // ----------------------------------------------------------------
  logic [7:0] trig_lvl;
  logic [7:0] trig_prev_reg;
  logic [7:0] trig_prev_next;
  logic [7:0] trig_rise;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic alert_evt;

  assign trig_lvl = {SRC_TRIG_I, PACK_BELOW_REMOVAL_I, BUS_BELOW_CONV_I};
  assign trig_rise = trig_lvl & ~trig_prev_reg;
  assign alert_evt = |trig_rise;

  generate
    for (genvar g = 0; g < tsr_pkg::FLAG_NUM; g++)
    begin : g_flag
      // Set wins; a read drops the flag once its source is gone
      always_comb
      begin
        flags_next[g] = trig_rise[g] || (flags_reg[g] && !(rd_flags && !trig_lvl[g]));
      end
    end
  endgenerate

  assign trig_prev_next = trig_lvl;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      flags_reg <= tsr_pkg::FLAGS_RESET;
      trig_prev_reg <= 8'h00;
    end
    else
    begin
      flags_reg <= flags_next;
      trig_prev_reg <= trig_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  tsr_pkg::tsr_ctrl_t ctrl_reg;
  tsr_pkg::tsr_ctrl_t ctrl_next;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    ctrl_next.clear_bit = tsr_pkg::CLEAR_IDLE_VAL;
    if (wr_ctrl)
    begin
      ctrl_next.hold_en = req.data[tsr_pkg::CTRL_HOLD_BIT];
      ctrl_next.width = req.data[tsr_pkg::CTRL_WIDTH_MSB:tsr_pkg::CTRL_WIDTH_LSB];
      ctrl_next.clear_bit = req.data[tsr_pkg::CTRL_CLEAR_BIT];
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_reg.hold_en <= tsr_pkg::CTRL_RESET[tsr_pkg::CTRL_HOLD_BIT];
      ctrl_reg.width <= tsr_pkg::CTRL_RESET[tsr_pkg::CTRL_WIDTH_MSB:tsr_pkg::CTRL_WIDTH_LSB];
      ctrl_reg.clear_bit <= tsr_pkg::CTRL_RESET[tsr_pkg::CTRL_CLEAR_BIT];
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // Alert pulse and hold
  // ----------------------------------------------------------------
  tsr_pkg::tsr_alert_state_t alert_state_reg;
  tsr_pkg::tsr_alert_state_t alert_state_next;
  logic alert_n_reg;
  logic alert_n_next;
  logic [20:0] width_cycles;
  logic timer_load;
  logic timer_stop;
  logic timer_done;

  always_comb
  begin
    unique case (ctrl_reg.width)
      tsr_pkg::WIDTH_100US: width_cycles = W100US_CYC[20:0];
      tsr_pkg::WIDTH_1MS: width_cycles = W1MS_CYC[20:0];
      tsr_pkg::WIDTH_10MS: width_cycles = W10MS_CYC[20:0];
      tsr_pkg::WIDTH_5MS: width_cycles = W5MS_CYC[20:0];
    endcase
  end

  always_comb
  begin
    alert_state_next = alert_state_reg;
    timer_load = 1'b0;
    timer_stop = 1'b0;
    if (alert_evt)
    begin
      // New trigger restarts the pulse even over a clear
      alert_state_next = tsr_pkg::ALERT_PULSE;
      timer_load = 1'b1;
    end
    else
    begin
      unique case (alert_state_reg)
        tsr_pkg::ALERT_IDLE:
        begin
          alert_state_next = tsr_pkg::ALERT_IDLE;
        end
        tsr_pkg::ALERT_PULSE:
        begin
          if (clear_req)
          begin
            alert_state_next = tsr_pkg::ALERT_IDLE;
            timer_stop = 1'b1;
          end
          else if (timer_done)
          begin
            alert_state_next = ctrl_reg.hold_en ? tsr_pkg::ALERT_HOLD : tsr_pkg::ALERT_IDLE;
          end
        end
        tsr_pkg::ALERT_HOLD:
        begin
          if (clear_req)
          begin
            alert_state_next = tsr_pkg::ALERT_IDLE;
          end
        end
        default:
        begin
          alert_state_next = tsr_pkg::ALERT_IDLE;
        end
      endcase
    end
    alert_n_next = (alert_state_next == tsr_pkg::ALERT_IDLE);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      alert_state_reg <= tsr_pkg::ALERT_IDLE;
      alert_n_reg <= 1'b1;
    end
    else
    begin
      alert_state_reg <= alert_state_next;
      alert_n_reg <= alert_n_next;
    end
  end

  tsr_pulse_timer u_timer (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .load_i(timer_load),
    .stop_i(timer_stop),
    .count_i(width_cycles),
    .done_o(timer_done)
  );

  assign ALERT_N_O = alert_n_reg;

  // ----------------------------------------------------------------
  // Peak-power assist failure and exit
  // ----------------------------------------------------------------
  logic [3:0] fail_cnt_reg;
  logic [3:0] fail_cnt_next;
  logic fail_flag_reg;
  logic fail_flag_next;
  logic exit_flag_reg;
  logic exit_flag_next;
  logic in_assist_reg;
  logic in_assist_next;
  logic fail_clear;
  logic exit_clear;
  logic exit_evt;

  assign fail_clear = wr_ctrl && !req.data[tsr_pkg::CTRL_FAIL_BIT];
  assign exit_clear = wr_ctrl && !req.data[tsr_pkg::CTRL_EXIT_BIT];
  assign exit_evt = in_assist_reg && !IN_ASSIST_I;
  assign in_assist_next = IN_ASSIST_I;

  always_comb
  begin
    fail_cnt_next = fail_cnt_reg;
    fail_flag_next = fail_flag_reg;
    if (ASSIST_FAIL_I && !fail_flag_reg)
    begin
      fail_cnt_next = fail_cnt_reg + 4'h1;
      if (fail_cnt_reg >= tsr_pkg::ASSIST_FAIL_LIMIT)
      begin
        fail_flag_next = 1'b1;
      end
    end
    else if (fail_clear && fail_flag_reg)
    begin
      fail_cnt_next = 4'h0;
      fail_flag_next = 1'b0;
    end
    else if (ASSIST_OK_I)
    begin
      fail_cnt_next = 4'h0;
    end
    exit_flag_next = exit_evt || (exit_flag_reg && !exit_clear);
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      fail_cnt_reg <= 4'h0;
      fail_flag_reg <= tsr_pkg::CTRL_RESET[tsr_pkg::CTRL_FAIL_BIT];
      exit_flag_reg <= tsr_pkg::CTRL_RESET[tsr_pkg::CTRL_EXIT_BIT];
      in_assist_reg <= 1'b0;
    end
    else
    begin
      fail_cnt_reg <= fail_cnt_next;
      fail_flag_reg <= fail_flag_next;
      exit_flag_reg <= exit_flag_next;
      in_assist_reg <= in_assist_next;
    end
  end

  assign ASSIST_LATCH_OFF_O = fail_flag_reg;
  assign IN_ASSIST_STATUS_O = in_assist_reg;

  // ----------------------------------------------------------------
  // Input current limit and result registers
  // ----------------------------------------------------------------
  logic [7:0] lim_lo_reg;
  logic [7:0] lim_lo_next;
  logic [7:0] lim_hi_reg;
  logic [7:0] lim_hi_next;
  logic [7:0] psys_reg;
  logic [7:0] psys_next;
  logic [7:0] vbus_reg;
  logic [7:0] vbus_next;
  logic [12:0] limit_ma_reg;
  logic [12:0] limit_ma_next;

  always_comb
  begin
    lim_lo_next = wr_lim_lo ? req.data : lim_lo_reg;
    lim_hi_next = wr_lim_hi ? req.data : lim_hi_reg;
    if (OPT_DONE_I)
    begin
      lim_hi_next = {lim_hi_reg[7], OPT_LIMIT_I};
    end
    psys_next = RESULT_VALID_I ? PSYS_RESULT_I : psys_reg;
    vbus_next = RESULT_VALID_I ? VBUS_RESULT_I : vbus_reg;
    limit_ma_next = 13'(lim_hi_reg[tsr_pkg::LIM_CODE_W-1:0] * tsr_pkg::LIMIT_STEP_MA) +
                    tsr_pkg::LIMIT_OFFSET_MA;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      lim_lo_reg <= tsr_pkg::LIM_LO_RESET;
      lim_hi_reg <= tsr_pkg::LIM_HI_RESET;
      psys_reg <= tsr_pkg::RESULT_RESET;
      vbus_reg <= tsr_pkg::RESULT_RESET;
      limit_ma_reg <= 13'h0000;
    end
    else
    begin
      lim_lo_reg <= lim_lo_next;
      lim_hi_reg <= lim_hi_next;
      psys_reg <= psys_next;
      vbus_reg <= vbus_next;
      limit_ma_reg <= limit_ma_next;
    end
  end

  assign INPUT_LIMIT_MA_O = limit_ma_reg;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] ctrl_view;

  assign ctrl_view = {tsr_pkg::CTRL_RSVD7_VAL, ctrl_reg.hold_en, ctrl_reg.width, ctrl_reg.clear_bit,
                      tsr_pkg::CTRL_RSVD2_VAL, fail_flag_reg, exit_flag_reg};

  always_comb
  begin
    rdata_next = rdata_reg;
    if (req.rd)
    begin
      case (req.addr)
        tsr_pkg::ADDR_SRC_FLAGS: rdata_next = flags_reg;
        tsr_pkg::ADDR_CTRL: rdata_next = ctrl_view;
        tsr_pkg::ADDR_LIM_LO: rdata_next = lim_lo_reg;
        tsr_pkg::ADDR_LIM_HI: rdata_next = lim_hi_reg;
        tsr_pkg::ADDR_PSYS: rdata_next = psys_reg;
        tsr_pkg::ADDR_VBUS: rdata_next = vbus_reg;
        default: rdata_next = tsr_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA_O = rdata_reg;

endmodule // tsr_throttle_status_register_bank

// *** tsr_sva.sv ***
`timescale 1ns/1ns
module tsr_sva (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [5:0] SRC_TRIG_I,
  input wire logic PACK_BELOW_REMOVAL_I,
  input wire logic BUS_BELOW_CONV_I,
  input wire logic IN_ASSIST_I,
  input wire logic ASSIST_FAIL_I,
  input wire logic OPT_DONE_I,
  input wire logic [6:0] OPT_LIMIT_I,
  input wire logic ALERT_N_O,
  input wire logic ASSIST_LATCH_OFF_O,
  input wire logic IN_ASSIST_STATUS_O,
  input wire logic [12:0] INPUT_LIMIT_MA_O
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [7:0] trig;
  assign trig = {SRC_TRIG_I, PACK_BELOW_REMOVAL_I, BUS_BELOW_CONV_I};
  sequence s_trig_rise;
    (trig & ~$past(trig)) != 8'h00;
  endsequence
  sequence s_clr_wr;
    REG_WR_I && REG_ADDR_I == 8'h23 && !REG_WDATA_I[3];
  endsequence
  sequence s_fail_clr;
    REG_WR_I && REG_ADDR_I == 8'h23 && !REG_WDATA_I[1];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_alert_fires: assert property (s_trig_rise |-> ##[1:2] !ALERT_N_O)
    else $error("alert not asserted after trigger");
  a_clear_releases: assert property (s_clr_wr ##0 ((trig & ~$past(trig)) == 8'h00) |=> ALERT_N_O)
    else $error("alert not released by clear write");
  a_latch_cause: assert property ($rose(ASSIST_LATCH_OFF_O) |-> $past(ASSIST_FAIL_I))
    else $error("latch set without a failure");
  a_latch_holds: assert property (ASSIST_LATCH_OFF_O && !(REG_WR_I && REG_ADDR_I == 8'h23 && !REG_WDATA_I[1])
    |=> ASSIST_LATCH_OFF_O)
    else $error("latch dropped without clear");
  a_latch_clears: assert property (ASSIST_LATCH_OFF_O ##0 s_fail_clr ##0 !ASSIST_FAIL_I |=> !ASSIST_LATCH_OFF_O)
    else $error("latch not cleared by write");
  a_limit_update: assert property (OPT_DONE_I |-> ##2
    INPUT_LIMIT_MA_O == $past(OPT_LIMIT_I, 2) * 13'h0032 + 13'h0032)
    else $error("applied limit not updated by optimizer");
  a_status_copy: assert property ($past(RST_N_I) |-> IN_ASSIST_STATUS_O == $past(IN_ASSIST_I))
    else $error("in-assist status wrong");
  a_rsvd_read: assert property (REG_RD_I && REG_ADDR_I == 8'h23 |=> REG_RDATA_O[7] && !REG_RDATA_O[2])
    else $error("reserved control bits changed");
endmodule // tsr_sva

bind tsr_throttle_status_register_bank tsr_sva u_tsr_sva (
  .REF_CLK_I(REF_CLK_I),
  .RST_N_I(RST_N_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O),
  .SRC_TRIG_I(SRC_TRIG_I),
  .PACK_BELOW_REMOVAL_I(PACK_BELOW_REMOVAL_I),
  .BUS_BELOW_CONV_I(BUS_BELOW_CONV_I),
  .IN_ASSIST_I(IN_ASSIST_I),
  .ASSIST_FAIL_I(ASSIST_FAIL_I),
  .OPT_DONE_I(OPT_DONE_I),
  .OPT_LIMIT_I(OPT_LIMIT_I),
  .ALERT_N_O(ALERT_N_O),
  .ASSIST_LATCH_OFF_O(ASSIST_LATCH_OFF_O),
  .IN_ASSIST_STATUS_O(IN_ASSIST_STATUS_O),
  .INPUT_LIMIT_MA_O(INPUT_LIMIT_MA_O)
);

// *** tsr_host_model.sv ***
`timescale 1ns/1ns
module tsr_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'hff;
    wdata_o = 8'h00;
  end
  // ----------------------------------------------------------------
  // One strobe cycle; bus shows inverted values once released
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(negedge clk_i);
    q = rdata_i;
  endtask
  task automatic ctrl(input logic h, input logic [1:0] w, input logic clr, input logic f, input logic x);
    logic [7:0] q;
    xfer(1'b1, 8'h23, {1'b1, h, w, clr, 1'b0, f, x}, q);
  endtask
endmodule // tsr_host_model

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
  logic clk, rst_n, wr, rd, pack, bus, ina, fail, ok, opt_done, rv, alert_n, latch, ins;
  logic [7:0] addr, wdata, rdata, psys, vbus, q;
  logic [5:0] src;
  logic [6:0] opt_lim, c;
  logic [12:0] lim;
  logic [7:0] m [34:39];
  int err_count, compares, cyc, n, b;
  int wtab [4] = '{10, 20, 40, 30};
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  tsr_throttle_status_register_bank #(.W100US_CYC(10), .W1MS_CYC(20), .W10MS_CYC(40), .W5MS_CYC(30))
  u_tsr_throttle_status_register_bank (.REF_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SRC_TRIG_I(src), .PACK_BELOW_REMOVAL_I(pack),
    .BUS_BELOW_CONV_I(bus), .IN_ASSIST_I(ina), .ASSIST_FAIL_I(fail), .ASSIST_OK_I(ok), .OPT_DONE_I(opt_done),
    .OPT_LIMIT_I(opt_lim), .RESULT_VALID_I(rv), .PSYS_RESULT_I(psys), .VBUS_RESULT_I(vbus), .ALERT_N_O(alert_n),
    .ASSIST_LATCH_OFF_O(latch), .IN_ASSIST_STATUS_O(ins), .INPUT_LIMIT_MA_O(lim));
  tsr_host_model u_tsr_host_model (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));
  // ----------------------------------------------------------------
  // Checking and stimulus tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("COUNTS compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a);
    u_tsr_host_model.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), (a >= 8'h22 && a <= 8'h27) ? m[a] : 8'h00, q);
  endtask
  task automatic lim_chk();
    chk("limit", tsr_pkg::LIMIT_STEP_MA * m[37][6:0] + tsr_pkg::LIMIT_OFFSET_MA, lim);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic pulse_len(input int t, output int len);
    @(posedge clk) {src, pack, bus} <= 8'h01 << t;
    @(posedge clk) {src, pack, bus} <= 8'h00;
    @(negedge clk);
    len = 0;
    for (int i = 0; i < 3 && alert_n !== 1'b0; i++)
      @(negedge clk);
    while (alert_n === 1'b0 && len < 100)
    begin
      len++;
      @(negedge clk);
    end
  endtask
  task automatic fails(input int k);
    repeat (k)
    begin
      @(posedge clk) fail <= 1'b1;
      @(posedge clk) fail <= 1'b0;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, src, pack, bus, ina, fail, ok, opt_done, opt_lim, rv, psys, vbus} = '0;
    {err_count, compares, cyc} = '0;
    m = '{8'h00, 8'ha8, 8'h00, 8'h41, 8'h00, 8'h00};
    void'($urandom(32'h623c6bc0));
    tick(6);
    rst_n <= 1'b1;
    for (int a = 8'h21; a <= 8'h28; a++)
      rc(a[7:0]);
    lim_chk();
    $display("TEST reset done");
    for (int w = 0; w < 4; w++)
    begin
      b = $urandom_range(7, 0);
      u_tsr_host_model.ctrl(1'b0, w[1:0], 1'b1, 1'b1, 1'b1);
      m[35] = {2'b10, w[1:0], 4'h8};
      pulse_len(b, n);
      chk("width", wtab[w], n[12:0]);
      m[34][b] = 1'b1;
      rc(8'h22);
      m[34] = 8'h00;
      rc(8'h22);
    end
    $display("TEST widths done");
    u_tsr_host_model.ctrl(1'b1, 2'h0, 1'b1, 1'b1, 1'b1);
    m[35] = 8'hc8;
    rc(8'h23);
    b = $urandom_range(7, 0);
    pulse_len(b, n);
    chk("hold", 13'h0064, n[12:0]);
    u_tsr_host_model.ctrl(1'b1, 2'h0, 1'b0, 1'b1, 1'b1);
    chk("release", 13'h0001, alert_n);
    rc(8'h23);
    m[34][b] = 1'b1;
    rc(8'h22);
    m[34] = 8'h00;
    u_tsr_host_model.ctrl(1'b0, 2'h2, 1'b1, 1'b1, 1'b1);
    m[35] = 8'ha8;
    $display("TEST hold done");
    fails($urandom_range(7, 1));
    @(posedge clk) ok <= 1'b1;
    @(posedge clk) ok <= 1'b0;
    fails(7);
    tick(2);
    chk("latch", 13'h0000, latch);
    fails(1);
    tick(2);
    chk("latch", 13'h0001, latch);
    m[35][1] = 1'b1;
    u_tsr_host_model.ctrl(1'b0, 2'h2, 1'b1, 1'b1, 1'b1);
    rc(8'h23);
    u_tsr_host_model.ctrl(1'b0, 2'h2, 1'b1, 1'b0, 1'b1);
    m[35][1] = 1'b0;
    rc(8'h23);
    chk("latch", 13'h0000, latch);
    @(posedge clk) ina <= 1'b1;
    tick(2);
    chk("in_assist", 13'h0001, ins);
    @(posedge clk) ina <= 1'b0;
    tick(2);
    m[35][0] = 1'b1;
    u_tsr_host_model.ctrl(1'b0, 2'h2, 1'b1, 1'b1, 1'b1);
    rc(8'h23);
    u_tsr_host_model.ctrl(1'b0, 2'h2, 1'b1, 1'b1, 1'b0);
    m[35][0] = 1'b0;
    rc(8'h23);
    $display("TEST assist done");
    for (int i = 0; i < 3; i++)
    begin
      c = (i == 0) ? 7'h00 : 7'($urandom_range(127, 0));
      u_tsr_host_model.xfer(1'b1, 8'h25, {1'b0, c}, q);
      m[37] = {1'b0, c};
      rc(8'h25);
      lim_chk();
    end
    @(posedge clk)
    begin
      opt_done <= 1'b1;
      opt_lim <= 7'($urandom_range(127, 0));
    end
    @(posedge clk) opt_done <= 1'b0;
    m[37] = {1'b0, opt_lim};
    tick(2);
    rc(8'h25);
    lim_chk();
    $display("TEST limit done");
    @(posedge clk)
    begin
      rv <= 1'b1;
      psys <= 8'($urandom);
      vbus <= 8'($urandom);
    end
    @(posedge clk) rv <= 1'b0;
    m[38] = psys;
    m[39] = vbus;
    u_tsr_host_model.xfer(1'b1, 8'h22, 8'h5a, q);
    u_tsr_host_model.xfer(1'b1, 8'h26, 8'h5a, q);
    u_tsr_host_model.xfer(1'b1, 8'h27, 8'h5a, q);
    for (int a = 8'h22; a <= 8'h27; a++)
      rc(a[7:0]);
    $display("TEST results done");
    final_report();
  end
endmodule // tb
